/* logic/aao_core.sv */
// accumulator datapath for subtract-borrow, swap, direction load and xor
// Notes on behaviour
// - subtract w and inverted carry from file register
// - subtract result to w if d=0, else file
// - swap file register nibbles, flags untouched
// - swap result to w if d=0, else file
// - operand 5/6/7 loads port a/b/c direction
// - xor w with immediate into w, zero only
// - xor w with file, d selects destination
// - carry and digit carry mean no borrow
`timescale 1ns/1ps
module aao_core (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic      [7:0]  port_a_direction,
    output logic      [7:0]  port_b_direction,
    output logic      [7:0]  port_c_direction
);
    aao_alu_if alu_bus ();

    logic [7:0]  w_q;
    logic        c_q;
    logic        half_nibble_carry_flag_q;
    logic        z_q;
    logic [6:0]  faddr_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [7:0]  file_mem [aao_pkg::AAO_FILE_DEPTH];

    logic        wr_take;
    logic        exec;
    logic        dest_file;
    logic [6:0]  cmd_f;
    logic        wr_w_alu;
    logic        wr_f_alu;
    logic [31:0] rdata_d;

    aao_alu u_alu (
        .a (alu_bus.alu)
    );

    // one wait cycle per access keeps read data a plain flop
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    // writes land on the edge where waitrequest is low; lane 0 must be enabled
    assign wr_take   = avs_write & ack_q & avs_byteenable[0];
    assign exec      = wr_take & (avs_address == aao_pkg::AAO_CMD_OFS);
    assign dest_file = avs_writedata[aao_pkg::AAO_CMD_D_BIT];
    assign cmd_f     = avs_writedata[aao_pkg::AAO_CMD_F_LSB +: 7];

    // alu operands come straight from the command word and current state
    always_comb begin
        alu_bus.op    = aao_pkg::aao_op_type'(avs_writedata[aao_pkg::AAO_CMD_OP_LSB +: 3]);
        alu_bus.f_val = file_mem[cmd_f];
        alu_bus.w_val = w_q;
        alu_bus.k_val = avs_writedata[aao_pkg::AAO_CMD_K_LSB +: 8];
        alu_bus.c_in  = c_q;
    end

    // destination steering; immediate xor always targets w
    always_comb begin
        wr_w_alu = 1'b0;
        wr_f_alu = 1'b0;
        if (exec) begin
            case (alu_bus.op)
                aao_pkg::AAO_SUBTRACT_WITH_BORROW_OP,
                aao_pkg::AAO_NIBBLE_SWAP_OP,
                aao_pkg::AAO_XOR_FILE_OP: begin
                    wr_w_alu = ~dest_file;
                    wr_f_alu = dest_file;
                end
                aao_pkg::AAO_XOR_IMMEDIATE_OP: begin
                    wr_w_alu = 1'b1;
                end
                default: begin
                    wr_w_alu = 1'b0;
                end
            endcase
        end
    end

    // accumulator: alu result or a direct bus write
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            w_q <= aao_pkg::AAO_WREG_RST;
        end else if (wr_w_alu) begin
            w_q <= alu_bus.result;
        end else if (wr_take && avs_address == aao_pkg::AAO_WREG_OFS) begin
            w_q <= avs_writedata[7:0];
        end
    end

    // flags: only ops that own a flag touch it, swap and direction load touch none
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            c_q                      <= 1'b0;
            half_nibble_carry_flag_q <= 1'b0;
            z_q                      <= 1'b0;
        end else if (exec) begin
            if (alu_bus.upd_cdc) begin
                c_q                      <= alu_bus.c_out;
                half_nibble_carry_flag_q <= alu_bus.dc_out;
            end
            if (alu_bus.upd_z) begin
                z_q <= (alu_bus.result == 8'h00);
            end
        end else if (wr_take && avs_address == aao_pkg::AAO_STATUS_OFS) begin
            c_q                      <= avs_writedata[aao_pkg::AAO_STAT_C_BIT];
            half_nibble_carry_flag_q <= avs_writedata[aao_pkg::AAO_STAT_DC_BIT];
            z_q                      <= avs_writedata[aao_pkg::AAO_STAT_Z_BIT];
        end
    end

    // direction registers load only from the accumulator; other operands are ignored
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_a_direction <= aao_pkg::AAO_DIR_RST;
            port_b_direction <= aao_pkg::AAO_DIR_RST;
            port_c_direction <= aao_pkg::AAO_DIR_RST;
        end else if (exec && alu_bus.op == aao_pkg::AAO_DIRECTION_LOAD_OP) begin
            if (cmd_f == aao_pkg::AAO_SEL_PORT_A) begin
                port_a_direction <= w_q;
            end
            if (cmd_f == aao_pkg::AAO_SEL_PORT_B) begin
                port_b_direction <= w_q;
            end
            if (cmd_f == aao_pkg::AAO_SEL_PORT_C) begin
                port_c_direction <= w_q;
            end
        end
    end

    // file pointer for bus access to the register file
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            faddr_q <= 7'h00;
        end else if (wr_take && avs_address == aao_pkg::AAO_FADDR_OFS) begin
            faddr_q <= avs_writedata[6:0];
        end
    end

    // register file has no reset: contents are data, not control
    always_ff @(posedge clk) begin
        if (wr_f_alu) begin
            file_mem[cmd_f] <= alu_bus.result;
        end else if (wr_take && avs_address == aao_pkg::AAO_FDATA_OFS) begin
            file_mem[faddr_q] <= avs_writedata[7:0];
        end
    end

    // read mux; unmapped offsets and the command word read as zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (avs_address)
            aao_pkg::AAO_WREG_OFS:   rdata_d[7:0] = w_q;
            aao_pkg::AAO_STATUS_OFS: begin
                rdata_d[aao_pkg::AAO_STAT_C_BIT]  = c_q;
                rdata_d[aao_pkg::AAO_STAT_DC_BIT] = half_nibble_carry_flag_q;
                rdata_d[aao_pkg::AAO_STAT_Z_BIT]  = z_q;
            end
            aao_pkg::AAO_DIRA_OFS:   rdata_d[7:0] = port_a_direction;
            aao_pkg::AAO_DIRB_OFS:   rdata_d[7:0] = port_b_direction;
            aao_pkg::AAO_DIRC_OFS:   rdata_d[7:0] = port_c_direction;
            aao_pkg::AAO_FADDR_OFS:  rdata_d[6:0] = faddr_q;
            aao_pkg::AAO_FDATA_OFS:  rdata_d[7:0] = file_mem[faddr_q];
            default:                 rdata_d = 32'h0000_0000;
        endcase
    end

    // sampled in the wait cycle so data stands when waitrequest drops
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read && !ack_q) begin
            rdata_q <= rdata_d;
        end
    end
    assign avs_readdata = rdata_q;

    // ---- checks ----
    logic       exp_nb;
    logic       exp_dc_nb;
    logic [7:0] exp_sub;
    // independent reference for subtract flags via magnitude compare
    always_comb begin
        exp_sub   = 8'(alu_bus.f_val - alu_bus.w_val - {7'h00, ~c_q});
        exp_nb    = {1'b0, alu_bus.f_val} >= ({1'b0, alu_bus.w_val} + {8'h00, ~c_q});
        exp_dc_nb = {1'b0, alu_bus.f_val[3:0]} >= ({1'b0, alu_bus.w_val[3:0]} + {4'h0, ~c_q});
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_wait_one_cycle: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held past one cycle");
    a_sub_carry_flags: assert property (
        exec && alu_bus.op == aao_pkg::AAO_SUBTRACT_WITH_BORROW_OP
        |=> c_q == $past(exp_nb) && half_nibble_carry_flag_q == $past(exp_dc_nb))
        else $error("subtract carry or digit carry wrong");
    a_sub_to_w: assert property (
        exec && alu_bus.op == aao_pkg::AAO_SUBTRACT_WITH_BORROW_OP && !dest_file
        |=> w_q == $past(exp_sub) && z_q == ($past(exp_sub) == 8'h00))
        else $error("subtract result in w wrong");
    a_sub_to_file: assert property (
        exec && alu_bus.op == aao_pkg::AAO_SUBTRACT_WITH_BORROW_OP && dest_file
        |=> $stable(w_q) && file_mem[$past(cmd_f)] == $past(exp_sub))
        else $error("subtract to file wrong");
    a_swap_no_flags: assert property (
        exec && alu_bus.op == aao_pkg::AAO_NIBBLE_SWAP_OP
        |=> $stable(c_q) && $stable(half_nibble_carry_flag_q) && $stable(z_q))
        else $error("swap changed a flag");
    a_swap_to_w: assert property (
        exec && alu_bus.op == aao_pkg::AAO_NIBBLE_SWAP_OP && !dest_file
        |=> w_q == {$past(alu_bus.f_val[3:0]), $past(alu_bus.f_val[7:4])})
        else $error("swap result in w wrong");
    a_dir_load_b: assert property (
        exec && alu_bus.op == aao_pkg::AAO_DIRECTION_LOAD_OP && cmd_f == aao_pkg::AAO_SEL_PORT_B
        |=> port_b_direction == $past(w_q) && $stable(port_a_direction) && $stable(c_q))
        else $error("direction load to port b wrong");
    a_xor_imm_zero: assert property (
        exec && alu_bus.op == aao_pkg::AAO_XOR_IMMEDIATE_OP
        |=> w_q == ($past(w_q) ^ $past(alu_bus.k_val)) && $stable(c_q)
            && z_q == (w_q == 8'h00))
        else $error("xor immediate wrong");
    a_xor_file_dest: assert property (
        exec && alu_bus.op == aao_pkg::AAO_XOR_FILE_OP && dest_file
        |=> $stable(w_q) && $stable(half_nibble_carry_flag_q)
            && z_q == ($past(w_q ^ alu_bus.f_val) == 8'h00))
        else $error("xor to file wrong");
    a_zero_nonzero: assert property (
        exec && alu_bus.upd_z && alu_bus.result != 8'h00 |=> !z_q)
        else $error("zero flag set on nonzero result");

    c_sub_borrow: cover property (exec && alu_bus.op == aao_pkg::AAO_SUBTRACT_WITH_BORROW_OP
                                  && !c_q ##1 z_q);
    c_swap_file:  cover property (exec && alu_bus.op == aao_pkg::AAO_NIBBLE_SWAP_OP && dest_file);
    c_dir_c:      cover property (exec && alu_bus.op == aao_pkg::AAO_DIRECTION_LOAD_OP
                                  && cmd_f == aao_pkg::AAO_SEL_PORT_C);
endmodule : aao_core

/* logic/aao_pkg.sv */
// constants and types shared by the accumulator datapath files
package aao_pkg;
    // register byte offsets on the avalon slave
    localparam logic [7:0] AAO_CMD_OFS    = 8'h00;
    localparam logic [7:0] AAO_WREG_OFS   = 8'h04;
    localparam logic [7:0] AAO_STATUS_OFS = 8'h08;
    localparam logic [7:0] AAO_DIRA_OFS   = 8'h0c;
    localparam logic [7:0] AAO_DIRB_OFS   = 8'h10;
    localparam logic [7:0] AAO_DIRC_OFS   = 8'h14;
    localparam logic [7:0] AAO_FADDR_OFS  = 8'h18;
    localparam logic [7:0] AAO_FDATA_OFS  = 8'h1c;

    // command word fields
    localparam int AAO_CMD_OP_LSB = 0;
    localparam int AAO_CMD_D_BIT  = 3;
    localparam int AAO_CMD_F_LSB  = 4;
    localparam int AAO_CMD_K_LSB  = 16;

    // status bit positions
    localparam int AAO_STAT_C_BIT  = 0;
    localparam int AAO_STAT_DC_BIT = 1;
    localparam int AAO_STAT_Z_BIT  = 2;

    // direction-load operand selects
    localparam logic [6:0] AAO_SEL_PORT_A = 7'h05;
    localparam logic [6:0] AAO_SEL_PORT_B = 7'h06;
    localparam logic [6:0] AAO_SEL_PORT_C = 7'h07;

    // reset values and register file depth
    localparam logic [7:0] AAO_DIR_RST  = 8'hff;
    localparam logic [7:0] AAO_WREG_RST = 8'h00;
    localparam int         AAO_FILE_DEPTH = 128;

    typedef enum logic [2:0] {
        AAO_NO_OP                   = 3'h0,
        AAO_SUBTRACT_WITH_BORROW_OP = 3'h1,
        AAO_NIBBLE_SWAP_OP          = 3'h2,
        AAO_DIRECTION_LOAD_OP       = 3'h3,
        AAO_XOR_IMMEDIATE_OP        = 3'h4,
        AAO_XOR_FILE_OP             = 3'h5
    } aao_op_type;
endpackage : aao_pkg

/* logic/aao_alu_if.sv */
// operand and result bundle between the datapath core and its alu
`timescale 1ns/1ps
interface aao_alu_if;
    aao_pkg::aao_op_type op;
    logic [7:0]          f_val;
    logic [7:0]          w_val;
    logic [7:0]          k_val;
    logic                c_in;
    logic [7:0]          result;
    logic                c_out;
    logic                dc_out;
    logic                upd_z;
    logic                upd_cdc;

    modport core (output op, output f_val, output w_val, output k_val, output c_in,
                  input result, input c_out, input dc_out, input upd_z, input upd_cdc);
    modport alu  (input op, input f_val, input w_val, input k_val, input c_in,
                  output result, output c_out, output dc_out, output upd_z, output upd_cdc);
endinterface : aao_alu_if

/* logic/aao_alu.sv */
// combinational alu for the accumulator instruction subset
`timescale 1ns/1ps
module aao_alu (
    aao_alu_if.alu a
);
    logic [8:0] sub_full;
    logic [4:0] sub_low;

    // subtract as f + ~w + carry: carry in is the inverse of the pending borrow
    always_comb begin
        sub_full  = {1'b0, a.f_val} + {1'b0, ~a.w_val} + {8'h00, a.c_in};
        sub_low   = {1'b0, a.f_val[3:0]} + {1'b0, ~a.w_val[3:0]} + {4'h0, a.c_in};
        a.result  = 8'h00;
        a.c_out   = sub_full[8];
        a.dc_out  = sub_low[4];
        a.upd_z   = 1'b0;
        a.upd_cdc = 1'b0;
        case (a.op)
            aao_pkg::AAO_SUBTRACT_WITH_BORROW_OP: begin
                a.result  = sub_full[7:0];
                a.upd_z   = 1'b1;
                a.upd_cdc = 1'b1;
            end
            aao_pkg::AAO_NIBBLE_SWAP_OP: begin
                a.result = {a.f_val[3:0], a.f_val[7:4]};
            end
            aao_pkg::AAO_XOR_IMMEDIATE_OP: begin
                a.result = a.w_val ^ a.k_val;
                a.upd_z  = 1'b1;
            end
            aao_pkg::AAO_XOR_FILE_OP: begin
                a.result = a.w_val ^ a.f_val;
                a.upd_z  = 1'b1;
            end
            default: begin
                a.result = a.w_val;  // direction load passes the accumulator through
            end
        endcase
    end
endmodule : aao_alu

/* verification/aao_core_tb.sv */
// self-checking testbench for the accumulator datapath register slave
`timescale 1ns/1ps
module aao_core_tb;
    logic        clk;
    logic        sys_rst;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  port_a_direction;
    logic [7:0]  port_b_direction;
    logic [7:0]  port_c_direction;
    int          n_fail;
    int          checks;
    logic [31:0] rd;

    aao_core dut (
        .clk              (clk),
        .sys_rst          (sys_rst),
        .avs_address      (avs_address),
        .avs_read         (avs_read),
        .avs_write        (avs_write),
        .avs_writedata    (avs_writedata),
        .avs_byteenable   (avs_byteenable),
        .avs_readdata     (avs_readdata),
        .avs_waitrequest  (avs_waitrequest),
        .port_a_direction (port_a_direction),
        .port_b_direction (port_b_direction),
        .port_c_direction (port_c_direction)
    );

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    // one compare task serves every register and port value
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // request is held until waitrequest is sampled low at a rising edge
    task automatic bus_access(input logic wr, input logic [7:0] adr, input logic [31:0] dat,
                              input logic [3:0] be, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        avs_address    <= adr;
        avs_writedata  <= dat;
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        if (n >= 50) check("waitrequest timeout", 32'h0, 32'h1);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus_access

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] q;
        bus_access(1'b1, adr, dat, 4'hf, q);
    endtask : wr

    task automatic rd_chk(input string name, input logic [7:0] adr, input logic [31:0] exp);
        bus_access(1'b0, adr, 32'h0, 4'hf, rd);
        check(name, exp, rd);
    endtask : rd_chk

    task automatic exec(input logic [2:0] op, input logic d, input logic [6:0] f,
                        input logic [7:0] k);
        wr(aao_pkg::AAO_CMD_OFS, {8'h00, k, 5'h00, f, d, op});
    endtask : exec

    task automatic set_file(input logic [6:0] f, input logic [7:0] v);
        wr(aao_pkg::AAO_FADDR_OFS, {25'h0, f});
        wr(aao_pkg::AAO_FDATA_OFS, {24'h0, v});
    endtask : set_file

    // subtract with borrow, expected flags worked out on nine and five bits
    task automatic run_sub(input logic [7:0] f, input logic [7:0] w, input logic c,
                           input logic d);
        logic [8:0] full;
        logic [4:0] low;
        logic [7:0] res;
        full = {1'b0, f} - {1'b0, w} - {8'h00, ~c};
        low  = {1'b0, f[3:0]} - {1'b0, w[3:0]} - {4'h0, ~c};
        res  = full[7:0];
        set_file(7'h21, f);
        wr(aao_pkg::AAO_WREG_OFS, {24'h0, w});
        wr(aao_pkg::AAO_STATUS_OFS, {31'h0, c});
        exec(aao_pkg::AAO_SUBTRACT_WITH_BORROW_OP, d, 7'h21, 8'h00);
        rd_chk("sub w", aao_pkg::AAO_WREG_OFS, {24'h0, d ? w : res});
        rd_chk("sub file", aao_pkg::AAO_FDATA_OFS, {24'h0, d ? res : f});
        rd_chk("sub flags", aao_pkg::AAO_STATUS_OFS,
               {29'h0, res == 8'h00, ~low[4], ~full[8]});
    endtask : run_sub

    task automatic t_reset();
        check("port a dir", {24'h0, aao_pkg::AAO_DIR_RST}, {24'h0, port_a_direction});
        check("port b dir", {24'h0, aao_pkg::AAO_DIR_RST}, {24'h0, port_b_direction});
        check("port c dir", {24'h0, aao_pkg::AAO_DIR_RST}, {24'h0, port_c_direction});
        rd_chk("w reset", aao_pkg::AAO_WREG_OFS, 32'h0);
        rd_chk("status reset", aao_pkg::AAO_STATUS_OFS, 32'h0);
        rd_chk("unmapped", 8'h40, 32'h0);
        rd_chk("cmd read", aao_pkg::AAO_CMD_OFS, 32'h0);
    endtask : t_reset

    task automatic t_sub();
        run_sub(8'h50, 8'h20, 1'b1, 1'b0);
        run_sub(8'h50, 8'h20, 1'b0, 1'b1);
        run_sub(8'h10, 8'h01, 1'b1, 1'b0);
        run_sub(8'h05, 8'h05, 1'b1, 1'b1);
        run_sub(8'h05, 8'h04, 1'b0, 1'b0);
        run_sub(8'h00, 8'h00, 1'b0, 1'b1);
        run_sub(8'h3c, 8'h7d, 1'b1, 1'b0);
    endtask : t_sub

    // flags are preset to all ones so any change shows
    task automatic t_swap();
        set_file(7'h7f, 8'ha5);
        wr(aao_pkg::AAO_WREG_OFS, 32'h11);
        wr(aao_pkg::AAO_STATUS_OFS, 32'h7);
        exec(aao_pkg::AAO_NIBBLE_SWAP_OP, 1'b0, 7'h7f, 8'h00);
        rd_chk("swap w", aao_pkg::AAO_WREG_OFS, 32'h5a);
        rd_chk("swap file kept", aao_pkg::AAO_FDATA_OFS, 32'ha5);
        exec(aao_pkg::AAO_NIBBLE_SWAP_OP, 1'b1, 7'h7f, 8'h00);
        rd_chk("swap file", aao_pkg::AAO_FDATA_OFS, 32'h5a);
        rd_chk("swap w kept", aao_pkg::AAO_WREG_OFS, 32'h5a);
        rd_chk("swap flags", aao_pkg::AAO_STATUS_OFS, 32'h7);
    endtask : t_swap

    task automatic t_dir();
        wr(aao_pkg::AAO_STATUS_OFS, 32'h5);
        wr(aao_pkg::AAO_WREG_OFS, 32'h00);
        exec(aao_pkg::AAO_DIRECTION_LOAD_OP, 1'b0, 7'h05, 8'h00);
        wr(aao_pkg::AAO_WREG_OFS, 32'h3c);
        exec(aao_pkg::AAO_DIRECTION_LOAD_OP, 1'b0, 7'h06, 8'h00);
        wr(aao_pkg::AAO_WREG_OFS, 32'h81);
        exec(aao_pkg::AAO_DIRECTION_LOAD_OP, 1'b1, 7'h07, 8'h00);
        wr(aao_pkg::AAO_WREG_OFS, 32'h99);
        exec(aao_pkg::AAO_DIRECTION_LOAD_OP, 1'b0, 7'h04, 8'h00);
        wr(aao_pkg::AAO_DIRA_OFS, 32'h77);
        check("port a", 32'h00, {24'h0, port_a_direction});
        check("port b", 32'h3c, {24'h0, port_b_direction});
        check("port c", 32'h81, {24'h0, port_c_direction});
        rd_chk("dir a read", aao_pkg::AAO_DIRA_OFS, 32'h00);
        rd_chk("dir c read", aao_pkg::AAO_DIRC_OFS, 32'h81);
        rd_chk("dir flags", aao_pkg::AAO_STATUS_OFS, 32'h5);
    endtask : t_dir

    // carry and digit carry must survive both xor forms
    task automatic t_xor();
        logic [31:0] q;
        wr(aao_pkg::AAO_WREG_OFS, 32'hc3);
        wr(aao_pkg::AAO_STATUS_OFS, 32'h3);
        exec(aao_pkg::AAO_XOR_IMMEDIATE_OP, 1'b1, 7'h00, 8'hc3);
        rd_chk("xorimm w zero", aao_pkg::AAO_WREG_OFS, 32'h00);
        rd_chk("xorimm flags", aao_pkg::AAO_STATUS_OFS, 32'h7);
        exec(aao_pkg::AAO_XOR_IMMEDIATE_OP, 1'b0, 7'h00, 8'h96);
        rd_chk("xorimm w", aao_pkg::AAO_WREG_OFS, 32'h96);
        rd_chk("xorimm nz", aao_pkg::AAO_STATUS_OFS, 32'h3);
        set_file(7'h10, 8'h0f);
        exec(aao_pkg::AAO_XOR_FILE_OP, 1'b1, 7'h10, 8'h00);
        rd_chk("xorf file", aao_pkg::AAO_FDATA_OFS, 32'h99);
        rd_chk("xorf w kept", aao_pkg::AAO_WREG_OFS, 32'h96);
        wr(aao_pkg::AAO_STATUS_OFS, 32'h4);
        set_file(7'h11, 8'h96);
        exec(aao_pkg::AAO_XOR_FILE_OP, 1'b0, 7'h11, 8'h00);
        rd_chk("xorf w", aao_pkg::AAO_WREG_OFS, 32'h00);
        rd_chk("xorf file kept", aao_pkg::AAO_FDATA_OFS, 32'h96);
        rd_chk("xorf flags", aao_pkg::AAO_STATUS_OFS, 32'h4);
        bus_access(1'b1, aao_pkg::AAO_WREG_OFS, 32'h55, 4'he, q);
        rd_chk("masked write", aao_pkg::AAO_WREG_OFS, 32'h00);
    endtask : t_xor

    // the run needs a few hundred cycles; this limit only catches a hang
    initial begin
        #20000;
        n_fail++;
        print_verdict();
    end

    initial begin
        sys_rst        = 1'b1;
        avs_address    = 8'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'h0;
        n_fail         = 0;
        checks         = 0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_sub();
        t_swap();
        t_dir();
        t_xor();
        print_verdict();
    end
endmodule : aao_core_tb
